// [rtl/srs_map.svh]
// Frame layout and fixed values of the SPI register access slave.
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH

`define SRS_FRAME_BITS 56
`define SRS_CNT_W 6
`define SRS_CMD_BIT 55
`define SRS_HDR_CMD_BIT 23
`define SRS_CHAN_MSB 54
`define SRS_CHAN_LSB 53
`define SRS_DEV_MSB 52
`define SRS_DEV_LSB 48
`define SRS_REGN_MSB 47
`define SRS_REGN_LSB 32
`define SRS_DATA_MSB 31
`define SRS_DATA_LSB 0
`define SRS_CMD_READ 1'b0
`define SRS_CMD_WRITE 1'b1
`define SRS_CNT_FULL 6'h38
`define SRS_CNT_ZERO 6'h00
`define SRS_CNT_ONE 6'h01
`define SRS_IDX_FIRST 6'h37
`define SRS_DATA_ZERO 32'h0000_0000
`define SRS_HDR_ZERO 24'h00_0000
`define SRS_FRAME_ZERO 56'h00_0000_0000_0000

`endif

// [rtl/srs_pkg.sv]
// Types shared by the SPI register access slave.
`include "srs_map.svh"

package srs_pkg;
    typedef logic [1:0] srs_chan_t;
    typedef logic [4:0] srs_dev_t;
    typedef logic [15:0] srs_regn_t;
    typedef logic [31:0] srs_data_t;
    typedef logic [23:0] srs_hdr_t;
    typedef logic [`SRS_FRAME_BITS-1:0] srs_frame_t;
    typedef logic [`SRS_CNT_W-1:0] srs_cnt_t;
    typedef enum logic [1:0] {
        SRS_IDLE,
        SRS_SHIFT,
        SRS_HOLD
    } srs_state_t;
endpackage

// [rtl/srs_spi_slave.sv]
// SPI slave port giving an external master access to the device registers.
// How it works
// (R01) Slave select low enables; high floats MISO.
// (R02) MOSI sampled on every rising SCK edge.
// (R03) Each instruction is exactly 56 bits.
// (R04) Address is channel, device, register number.
// (R05) Bits travel MSB first, 55 down to 0.
// (R06) Command bit 0 reads, 1 writes.
// (R07) Fields sit at fixed frame bit positions.
// (R08) Writes store data; read data bits discarded.
// (R09) Read returns data of previous read address.
// (R10) MISO header echoes previous command and address.
// (R11) After a write, MISO data echoes written data.
// (R12) Write after read sends zero data field.
// (R13) Invalid address reads back as zero.
// (R14) Every read fetches, clearing clear-on-read registers.
// (R15) Master ends read sequences on a plain register.
// (R16) Default mode launches MISO on falling SCK.
// (R17) Fast mode launches MISO on rising SCK.
// (R18) Fast mode changes only MISO launch timing.
// (R19) After reset the echoed fields are zero.
`timescale 1ns/1ps
`include "srs_map.svh"

module srs_spi_slave (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // SPI pins.
    input wire logic spi_sck,
    input wire logic spi_mosi,
    input wire logic spi_ssn_n,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Port control.
    input wire logic fast_mode,
    // Register file access.
    output logic reg_wr_q,
    output logic reg_rd_q,
    output srs_pkg::srs_chan_t reg_chan_q,
    output srs_pkg::srs_dev_t reg_dev_q,
    output srs_pkg::srs_regn_t reg_num_q,
    output srs_pkg::srs_data_t reg_wdata_q,
    input wire srs_pkg::srs_data_t reg_rd_data,
    input wire logic reg_rd_hit
);
    import srs_pkg::*;

    // Frame word as sent on MISO: echoed command and address, then data.
    function automatic srs_frame_t frame_word(input srs_hdr_t hdr, input srs_data_t data);
        frame_word = {hdr, data};
    endfunction

    logic sck_s;
    logic mosi_s;
    logic ssn_n_s;
    logic sck_q;
    logic rise_e;
    logic fall_e;
    logic launch_e;
    logic load_e;
    logic done_e;
    logic cmd_e;

    srs_sync srs_sync_i (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .sck_in(spi_sck),
        .mosi_in(spi_mosi),
        .ssn_n_in(spi_ssn_n),
        .sck_s(sck_s),
        .mosi_s(mosi_s),
        .ssn_n_s(ssn_n_s)
    );

    srs_state_t state_q, state_d;
    srs_cnt_t bit_cnt_q, bit_cnt_d;
    srs_cnt_t tx_idx_q, tx_idx_d;
    srs_frame_t rx_q, rx_d;
    srs_frame_t tx_q, tx_d;
    srs_hdr_t prev_hdr_q, prev_hdr_d;
    srs_data_t prev_wdata_q, prev_wdata_d;
    srs_data_t rbuf_q, rbuf_d;
    logic cap_q, cap_d;
    logic miso_d, miso_oe_d;
    logic reg_wr_d, reg_rd_d;
    srs_chan_t reg_chan_d;
    srs_dev_t reg_dev_d;
    srs_regn_t reg_num_d;
    srs_data_t reg_wdata_d;

    // Edge detection on the synchronised SCK level.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck_s;
        end
    end

    always_comb begin
        rise_e = sck_s && !sck_q;
        fall_e = !sck_s && sck_q;
        load_e = (state_q == SRS_IDLE) && !ssn_n_s;
        done_e = (state_q == SRS_SHIFT) && (bit_cnt_q == `SRS_CNT_FULL) && !ssn_n_s;
        cmd_e = (state_q == SRS_SHIFT) && rise_e && (bit_cnt_q == `SRS_CNT_ZERO) && !ssn_n_s;
        if (fast_mode) begin
            launch_e = rise_e; // [R17] [R18]
        end else begin
            launch_e = fall_e && (bit_cnt_q != `SRS_CNT_ZERO); // [R16]
        end
    end

    // Frame state, receive and transmit.
    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        tx_idx_d = tx_idx_q;
        rx_d = rx_q;
        tx_d = tx_q;
        miso_d = spi_miso;
        miso_oe_d = spi_miso_oe;
        unique case (state_q)
            SRS_IDLE: begin
                miso_oe_d = 1'b0; // [R01]
                if (load_e) begin
                    state_d = SRS_SHIFT;
                    bit_cnt_d = `SRS_CNT_ZERO;
                    tx_idx_d = `SRS_IDX_FIRST;
                    // [R09] [R10] [R11]
                    tx_d = frame_word(prev_hdr_q,
                        prev_hdr_q[`SRS_HDR_CMD_BIT] ? prev_wdata_q : rbuf_q);
                    miso_d = prev_hdr_q[`SRS_HDR_CMD_BIT]; // [R05]
                    miso_oe_d = 1'b1;
                end
            end
            SRS_SHIFT: begin
                if (rise_e && (bit_cnt_q != `SRS_CNT_FULL)) begin
                    rx_d = {rx_q[`SRS_FRAME_BITS-2:0], mosi_s}; // [R02] [R05]
                    bit_cnt_d = bit_cnt_q + `SRS_CNT_ONE; // [R03]
                end
                if (cmd_e && (mosi_s == `SRS_CMD_WRITE)
                    && (prev_hdr_q[`SRS_HDR_CMD_BIT] == `SRS_CMD_READ)) begin
                    tx_d = frame_word(tx_q[`SRS_FRAME_BITS-1:`SRS_REGN_LSB], `SRS_DATA_ZERO); // [R12]
                end
                if (launch_e && (tx_idx_q != `SRS_CNT_ZERO)) begin
                    tx_idx_d = tx_idx_q - `SRS_CNT_ONE; // [R05]
                    miso_d = tx_q[tx_idx_q - `SRS_CNT_ONE]; // [R16] [R17]
                end
                if (done_e) begin
                    state_d = SRS_HOLD;
                end
            end
            SRS_HOLD: begin
                if (launch_e && (tx_idx_q != `SRS_CNT_ZERO)) begin
                    tx_idx_d = tx_idx_q - `SRS_CNT_ONE;
                    miso_d = tx_q[tx_idx_q - `SRS_CNT_ONE];
                end
            end
        endcase
        if (ssn_n_s) begin
            state_d = SRS_IDLE; // [R01]
            miso_oe_d = 1'b0;
        end
    end

    // Instruction completion and register file requests.
    always_comb begin
        reg_wr_d = 1'b0;
        reg_rd_d = 1'b0;
        reg_chan_d = reg_chan_q;
        reg_dev_d = reg_dev_q;
        reg_num_d = reg_num_q;
        reg_wdata_d = reg_wdata_q;
        prev_hdr_d = prev_hdr_q;
        prev_wdata_d = prev_wdata_q;
        rbuf_d = rbuf_q;
        cap_d = reg_rd_q;
        if (done_e) begin
            reg_chan_d = rx_q[`SRS_CHAN_MSB:`SRS_CHAN_LSB]; // [R04] [R07]
            reg_dev_d = rx_q[`SRS_DEV_MSB:`SRS_DEV_LSB]; // [R04] [R07]
            reg_num_d = rx_q[`SRS_REGN_MSB:`SRS_REGN_LSB]; // [R04] [R07]
            prev_hdr_d = rx_q[`SRS_FRAME_BITS-1:`SRS_REGN_LSB]; // [R10]
            if (rx_q[`SRS_CMD_BIT] == `SRS_CMD_WRITE) begin
                reg_wr_d = 1'b1; // [R06] [R08]
                reg_wdata_d = rx_q[`SRS_DATA_MSB:`SRS_DATA_LSB];
                prev_wdata_d = rx_q[`SRS_DATA_MSB:`SRS_DATA_LSB]; // [R11]
            end else begin
                reg_rd_d = 1'b1; // [R06] [R14]
            end
        end
        if (cap_q) begin
            rbuf_d = reg_rd_hit ? reg_rd_data : `SRS_DATA_ZERO; // [R09] [R13]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= SRS_IDLE;
            bit_cnt_q <= `SRS_CNT_ZERO;
            tx_idx_q <= `SRS_IDX_FIRST;
            rx_q <= `SRS_FRAME_ZERO;
            tx_q <= `SRS_FRAME_ZERO;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            reg_chan_q <= 2'h0;
            reg_dev_q <= 5'h00;
            reg_num_q <= 16'h0000;
            reg_wdata_q <= `SRS_DATA_ZERO;
            prev_hdr_q <= `SRS_HDR_ZERO; // [R19]
            prev_wdata_q <= `SRS_DATA_ZERO; // [R19]
            rbuf_q <= `SRS_DATA_ZERO; // [R19]
            cap_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            tx_idx_q <= tx_idx_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            spi_miso <= miso_d;
            spi_miso_oe <= miso_oe_d;
            reg_wr_q <= reg_wr_d;
            reg_rd_q <= reg_rd_d;
            reg_chan_q <= reg_chan_d;
            reg_dev_q <= reg_dev_d;
            reg_num_q <= reg_num_d;
            reg_wdata_q <= reg_wdata_d;
            prev_hdr_q <= prev_hdr_d;
            prev_wdata_q <= prev_wdata_d;
            rbuf_q <= rbuf_d;
            cap_q <= cap_d;
        end
    end

    // Checks on the port behaviour.
    miso_float_a: assert property ( // [R01]
        @(posedge clk_sys) disable iff (!resetn)
        ssn_n_s |=> !spi_miso_oe)
        else $error("MISO driven while slave select is high.");

    sample_count_a: assert property ( // [R02]
        @(posedge clk_sys) disable iff (!resetn)
        (state_q == SRS_SHIFT) && rise_e && !ssn_n_s && (bit_cnt_q != `SRS_CNT_FULL)
        |=> (bit_cnt_q == $past(bit_cnt_q) + `SRS_CNT_ONE) && (rx_q[0] == $past(mosi_s)))
        else $error("Rising SCK edge did not sample MOSI.");

    frame_len_a: assert property ( // [R03]
        @(posedge clk_sys) disable iff (!resetn)
        (reg_wr_q || reg_rd_q) |-> ($past(bit_cnt_q) == `SRS_CNT_FULL))
        else $error("Request issued without a full frame.");

    addr_split_a: assert property ( // [R04]
        @(posedge clk_sys) disable iff (!resetn)
        (reg_wr_q || reg_rd_q)
        |-> ({reg_chan_q, reg_dev_q, reg_num_q} == $past(rx_q[`SRS_CHAN_MSB:`SRS_REGN_LSB])))
        else $error("Address fields taken from wrong frame bits.");

    cmd_decode_a: assert property ( // [R06]
        @(posedge clk_sys) disable iff (!resetn)
        done_e |=> (reg_wr_q == $past(rx_q[`SRS_CMD_BIT])) && (reg_rd_q == !$past(rx_q[`SRS_CMD_BIT])))
        else $error("Command bit decoded wrongly.");

    write_data_a: assert property ( // [R08]
        @(posedge clk_sys) disable iff (!resetn)
        reg_wr_q |-> (reg_wdata_q == $past(rx_q[`SRS_DATA_MSB:`SRS_DATA_LSB])))
        else $error("Write data not taken from frame data field.");

    read_fetch_a: assert property ( // [R13]
        @(posedge clk_sys) disable iff (!resetn)
        reg_rd_q ##1 cap_q |=> (rbuf_q == ($past(reg_rd_hit) ? $past(reg_rd_data) : `SRS_DATA_ZERO)))
        else $error("Fetched read data not held correctly.");

    echo_load_a: assert property ( // [R10]
        @(posedge clk_sys) disable iff (!resetn)
        load_e |=> (tx_q[`SRS_FRAME_BITS-1:`SRS_REGN_LSB] == $past(prev_hdr_q))
        && (spi_miso == $past(prev_hdr_q[`SRS_HDR_CMD_BIT])) && spi_miso_oe)
        else $error("MISO header does not echo previous instruction.");

    pipe_data_a: assert property ( // [R09]
        @(posedge clk_sys) disable iff (!resetn)
        load_e |=> (tx_q[`SRS_DATA_MSB:`SRS_DATA_LSB]
        == ($past(prev_hdr_q[`SRS_HDR_CMD_BIT]) ? $past(prev_wdata_q) : $past(rbuf_q))))
        else $error("MISO data field not pipelined correctly.");

    zero_after_read_a: assert property ( // [R12]
        @(posedge clk_sys) disable iff (!resetn)
        cmd_e && (mosi_s == `SRS_CMD_WRITE) && (prev_hdr_q[`SRS_HDR_CMD_BIT] == `SRS_CMD_READ)
        |=> (tx_q[`SRS_DATA_MSB:`SRS_DATA_LSB] == `SRS_DATA_ZERO))
        else $error("Write after read did not send zero data.");

    slow_launch_a: assert property ( // [R16]
        @(posedge clk_sys) disable iff (!resetn)
        !$past(fast_mode) && $changed(spi_miso) |-> $past(fall_e || load_e))
        else $error("MISO changed off a falling edge in default mode.");

    fast_launch_a: assert property ( // [R17]
        @(posedge clk_sys) disable iff (!resetn)
        $past(fast_mode) && $changed(spi_miso) |-> $past(rise_e || load_e))
        else $error("MISO changed off a rising edge in fast mode.");
endmodule

// [rtl/srs_sync.sv]
// Two-stage synchroniser for the three SPI input pins.
`timescale 1ns/1ps

module srs_sync (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Raw pins.
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic ssn_n_in,
    // Synchronised levels.
    output logic sck_s,
    output logic mosi_s,
    output logic ssn_n_s
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 3'h4;
            sync_q <= 3'h4;
        end else begin
            meta_q <= {ssn_n_in, mosi_in, sck_in};
            sync_q <= meta_q;
        end
    end

    assign sck_s = sync_q[0];
    assign mosi_s = sync_q[1];
    assign ssn_n_s = sync_q[2];
endmodule

// [tb/srs_spi_master_model.sv]
// Behavioural SPI master that runs one instruction per call.
`timescale 1ns/1ps

module srs_spi_master_model (
    // SPI pins.
    output logic sck,
    output logic mosi,
    output logic ssn_n,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        ssn_n = 1'b1;
    end

    // Samples MISO just before each rise and just before each fall.
    task automatic xfer(input logic [55:0] tx, input int nbits,
                        output logic [55:0] rx, output logic [55:0] rxf);
        rx = '0;
        rxf = '0;
        #3;
        ssn_n = 1'b0;
        #100;
        for (int i = 55; i > 55 - nbits; i--) begin
            mosi = tx[i];
            #62.5;
            rx[i] = miso;
            sck = 1'b1;
            #62.5;
            rxf[i] = miso;
            sck = 1'b0;
        end
        #100;
        ssn_n = 1'b1;
        mosi = ~mosi;
        #100;
    endtask
endmodule

// [tb/srs_spi_slave_tb.sv]
// Self-checking bench for the SPI register access slave.
`timescale 1ns/1ps

module srs_spi_slave_tb;
    import srs_pkg::*;
    logic clk_sys, resetn, fast_mode, rd_q1, prev_wr;
    wire logic sck, mosi, ssn_n, miso_w;
    logic spi_miso, spi_miso_oe, reg_wr_q, reg_rd_q, reg_rd_hit;
    srs_chan_t reg_chan_q;
    srs_dev_t reg_dev_q;
    srs_regn_t reg_num_q;
    srs_data_t reg_wdata_q, reg_rd_data, prev_wd, prev_fetch;
    srs_data_t mem [16];
    srs_hdr_t prev_hdr;
    int n_errors, checked, n_wr, n_rd;

    assign miso_w = spi_miso_oe ? spi_miso : 1'bz;
    assign reg_rd_hit = (reg_dev_q != 5'h00);
    assign reg_rd_data = reg_rd_hit ? mem[reg_num_q[3:0]] : 32'hDEAD_BEEF;

    srs_spi_slave srs_spi_slave_i (.clk_sys(clk_sys), .resetn(resetn), .spi_sck(sck),
        .spi_mosi(mosi), .spi_ssn_n(ssn_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .fast_mode(fast_mode), .reg_wr_q(reg_wr_q), .reg_rd_q(reg_rd_q),
        .reg_chan_q(reg_chan_q), .reg_dev_q(reg_dev_q), .reg_num_q(reg_num_q),
        .reg_wdata_q(reg_wdata_q), .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit));
    srs_spi_master_model srs_spi_master_model_i (.sck(sck), .mosi(mosi), .ssn_n(ssn_n),
        .miso(miso_w));

    // Register file with one clear-on-read location at index 15.
    always @(posedge clk_sys) begin
        if (!resetn) begin
            rd_q1 <= 1'b0;
            n_wr <= 0;
            n_rd <= 0;
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 32'h0000_0000;
            end
        end else begin
            rd_q1 <= reg_rd_q;
            n_wr <= n_wr + int'(reg_wr_q === 1'b1);
            n_rd <= n_rd + int'(reg_rd_q === 1'b1);
            if (reg_wr_q === 1'b1) begin
                mem[reg_num_q[3:0]] <= reg_wdata_q;
            end
            if (rd_q1 === 1'b1 && reg_num_q[3:0] == 4'hF) begin
                mem[15] <= 32'h0000_0000;
            end
        end
    end

    task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [55:0] fr(logic w, logic [1:0] ch, logic [4:0] dv,
                                       logic [15:0] rn, logic [31:0] d);
        return {w, ch, dv, rn, d};
    endfunction

    // Runs one instruction and compares MISO, strobes and address outputs.
    task automatic frame(input logic [55:0] tx, input int nbits);
        logic [55:0] rx, rxf;
        logic [31:0] dat, fetch;
        int wr0, rd0;
        dat = prev_wr ? prev_wd : (tx[55] ? 32'h0000_0000 : prev_fetch);
        fetch = (tx[52:48] != 5'h00) ? mem[tx[35:32]] : 32'h0000_0000;
        wr0 = n_wr;
        rd0 = n_rd;
        srs_spi_master_model_i.xfer(tx, nbits, rx, rxf);
        repeat (10) @(negedge clk_sys);
        chk("oe after frame", 56'h0, 56'(spi_miso_oe));
        if (nbits < 56) begin
            chk("strobes", 56'(wr0 + rd0), 56'(n_wr + n_rd));
            return;
        end
        chk("miso", {prev_hdr, dat}, rx);
        if (fast_mode) begin
            chk("fast launch", 56'(rx[54:0]), 56'(rxf[55:1]));
        end else begin
            chk("default launch", rx, rxf);
        end
        chk("write strobes", 56'(wr0 + int'(tx[55])), 56'(n_wr));
        chk("read strobes", 56'(rd0 + int'(!tx[55])), 56'(n_rd));
        chk("address", 56'(tx[54:32]), 56'({reg_chan_q, reg_dev_q, reg_num_q}));
        if (tx[55]) begin
            chk("write data", 56'(tx[31:0]), 56'(reg_wdata_q));
            prev_wd = tx[31:0];
        end else begin
            prev_fetch = fetch;
        end
        prev_hdr = tx[55:32];
        prev_wr = tx[55];
    endtask

    task automatic t_writes;
        frame(fr(1, 2'h1, 5'h1E, 16'h0100, 32'hA5C3_0F01), 56);
        frame(fr(1, 2'h2, 5'h01, 16'h0002, 32'h1234_5678), 56);
        frame(fr(0, 2'h3, 5'h01, 16'h0002, 32'hFFFF_FFFF), 56);
        $display("test writes done");
    endtask

    task automatic t_reads;
        frame(fr(0, 2'h0, 5'h01, 16'h0003, 32'h0000_0000), 56);
        frame(fr(1, 2'h1, 5'h04, 16'h0003, 32'h0F0F_0F0F), 56);
        frame(fr(0, 2'h0, 5'h00, 16'h0007, 32'h0000_0000), 56);
        frame(fr(0, 2'h0, 5'h01, 16'h0003, 32'h0000_0000), 56);
        $display("test reads done");
    endtask

    task automatic t_cor;
        frame(fr(1, 2'h0, 5'h01, 16'h000F, 32'h8000_0001), 56);
        frame(fr(0, 2'h0, 5'h01, 16'h000F, 32'h0000_0000), 56);
        frame(fr(0, 2'h0, 5'h01, 16'h000F, 32'h0000_0000), 56);
        frame(fr(0, 2'h0, 5'h01, 16'h0003, 32'h0000_0000), 56);
        $display("test clear on read done");
    endtask

    task automatic t_fast;
        @(negedge clk_sys);
        fast_mode = 1'b1;
        frame(fr(1, 2'h3, 5'h09, 16'h0005, 32'hC0DE_5A5A), 56);
        frame(fr(0, 2'h3, 5'h09, 16'h0005, 32'h0000_0000), 56);
        frame(fr(0, 2'h3, 5'h09, 16'h0002, 32'h0000_0000), 56);
        @(negedge clk_sys);
        fast_mode = 1'b0;
        $display("test fast mode done");
    endtask

    task automatic t_abort;
        frame(fr(1, 2'h2, 5'h07, 16'h0009, 32'h5555_AAAA), 20);
        frame(fr(0, 2'h1, 5'h01, 16'h0001, 32'h0000_0000), 56);
        $display("test abort done");
    endtask

    task close_out;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #400000;
        n_errors++;
        close_out;
    end

    initial begin
        resetn = 1'b0;
        fast_mode = 1'b0;
        n_errors = 0;
        checked = 0;
        prev_hdr = '0;
        prev_wr = 1'b0;
        prev_wd = '0;
        prev_fetch = '0;
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (5) @(negedge clk_sys);
        chk("oe at idle", 56'h0, 56'(spi_miso_oe));
        t_writes;
        t_reads;
        t_cor;
        t_fast;
        t_abort;
        close_out;
    end
endmodule
